// file: src/gas_map.svh
`ifndef GAS_MAP_SVH
`define GAS_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define GAS_OFF_APERTURE_SIZE 8'hb4
`define GAS_OFF_TABLE_BASE 8'hb8

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define GAS_SIZE_MSB 5
`define GAS_BASE_LSB 12
`define GAS_SIZE_RESET 6'h00
`define GAS_BASE_RESET 20'h00000
`define GAS_ENTRY_SHIFT 2
`define GAS_MAX_APERTURE_MB 9'h100
`endif

// file: src/gas_pkg.sv
package gas_pkg;
  // Configuration access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } gas_cfg_req_t;

  // Translation entry fetch request towards memory
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } gas_fetch_t;

  typedef enum logic [1:0] {
    GAS_IDLE = 2'b01,
    GAS_FETCH = 2'b10
  } gas_state_t;
endpackage

// file: src/gas_aperture_regs.sv
`timescale 1ns/1ns
`include "gas_map.svh"

module gas_aperture_regs #(
  parameter int PAGE_W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire gas_pkg::gas_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic [5:0] aperture_base_writable,
  output logic [8:0] aperture_size_mb,
  input wire logic translation_buffer_enable,
  output logic translation_buffer_flush,
  input wire logic xlat_req,
  input wire logic [PAGE_W-1:0] xlat_page,
  input wire logic xlat_hit,
  output logic xlat_busy,
  output gas_pkg::gas_fetch_t fetch,
  input wire logic fetch_ack
);
  logic [5:0] aperture_size_mask;
  logic [19:0] table_base_pointer_field;
  gas_pkg::gas_state_t state;
  logic sel_size;
  logic sel_base;
  logic need_fetch;
  logic [5:0] next_aperture_size_mask;
  logic [8:0] next_aperture_size_mb;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    sel_size = 1'b0;
    sel_base = 1'b0;
    if (cfg_req.addr == `GAS_OFF_APERTURE_SIZE) begin
      sel_size = 1'b1;
    end else if (cfg_req.addr == `GAS_OFF_TABLE_BASE) begin
      sel_base = 1'b1;
    end
  end

  // ----------------------------------------
  // Size register
  // ----------------------------------------
  // Byte lane 0 only; bits 7..6 are not stored so they stay zero
  always_comb begin
    next_aperture_size_mask = aperture_size_mask;
    if (cfg_req.wr && sel_size && cfg_req.be[0]) begin
      next_aperture_size_mask = cfg_req.wdata[`GAS_SIZE_MSB:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aperture_size_mask <= `GAS_SIZE_RESET;
    end else begin
      aperture_size_mask <= next_aperture_size_mask;
    end
  end

  // Zero bits pin the aperture base bits low, set bits free them
  assign aperture_base_writable = aperture_size_mask;

  // Decoded from the next field value so the registered size moves with the field
  // Codes outside the table are taken as the largest aperture
  always_comb begin
    case (next_aperture_size_mask)
      6'h20: next_aperture_size_mb = 9'h080;
      6'h30: next_aperture_size_mb = 9'h040;
      6'h38: next_aperture_size_mb = 9'h020;
      6'h3c: next_aperture_size_mb = 9'h010;
      6'h3e: next_aperture_size_mb = 9'h008;
      6'h3f: next_aperture_size_mb = 9'h004;
      default: next_aperture_size_mb = `GAS_MAX_APERTURE_MB;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aperture_size_mb <= `GAS_MAX_APERTURE_MB;
    end else begin
      aperture_size_mb <= next_aperture_size_mb;
    end
  end

  // ----------------------------------------
  // Table base register
  // ----------------------------------------
  // Writable at any time; lane 1 only carries bits 15..12, low nibble reserved
  always_ff @(posedge core_clk) begin
    if (rst) begin
      table_base_pointer_field <= `GAS_BASE_RESET;
    end else if (cfg_req.wr && sel_base) begin
      if (cfg_req.be[1]) begin
        table_base_pointer_field[3:0] <= cfg_req.wdata[15:12];
      end
      if (cfg_req.be[2]) begin
        table_base_pointer_field[11:4] <= cfg_req.wdata[23:16];
      end
      if (cfg_req.be[3]) begin
        table_base_pointer_field[19:12] <= cfg_req.wdata[31:24];
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_rdata <= 32'h00000000;
    end else if (cfg_req.rd) begin
      if (sel_size) begin
        cfg_rdata <= {26'h0000000, aperture_size_mask};
      end else if (sel_base) begin
        cfg_rdata <= {table_base_pointer_field, 12'h000};
      end else begin
        cfg_rdata <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
    end
  end

  // ----------------------------------------
  // Translation entry fetch
  // ----------------------------------------
  // While disabled the buffer is held flushed and cached hits are ignored
  assign translation_buffer_flush = !translation_buffer_enable;
  assign need_fetch = xlat_req && (!xlat_hit || !translation_buffer_enable);
  assign xlat_busy = (state == gas_pkg::GAS_FETCH);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= gas_pkg::GAS_IDLE;
    end else begin
      case (state)
        gas_pkg::GAS_IDLE: begin
          if (need_fetch) begin
            state <= gas_pkg::GAS_FETCH;
          end
        end
        gas_pkg::GAS_FETCH: begin
          if (fetch_ack) begin
            state <= gas_pkg::GAS_IDLE;
          end
        end
        default: state <= gas_pkg::GAS_IDLE;
      endcase
    end
  end

  // Address is captured at request time so a later base write cannot tear it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fetch <= '0;
    end else if (state == gas_pkg::GAS_IDLE && need_fetch) begin
      fetch.valid <= 1'b1;
      fetch.addr <= {table_base_pointer_field, 12'h000}
        + 32'({xlat_page, 2'b00});
    end else if (fetch_ack) begin
      fetch.valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_reserved_base_zero;
    @(posedge core_clk) disable iff (rst)
      cfg_rvalid && $past(cfg_req.rd && sel_base) |-> cfg_rdata[11:0] == 12'h000;
  endproperty
  a_reserved_base_zero: assert property (p_reserved_base_zero)
    else $error("Reserved base bits read nonzero");

  property p_size_readback;
    @(posedge core_clk) disable iff (rst)
      cfg_req.wr && sel_size && cfg_req.be[0] && !cfg_req.rd ##1 !cfg_req.wr
      ##1 cfg_req.rd && sel_size
      |=> cfg_rdata == {26'h0000000, $past(cfg_req.wdata[5:0], 3)};
  endproperty
  a_size_readback: assert property (p_size_readback)
    else $error("Size field readback mismatch");

  property p_mask_follows;
    @(posedge core_clk) disable iff (rst)
      cfg_req.wr && sel_size && cfg_req.be[0]
      |=> aperture_base_writable == $past(cfg_req.wdata[5:0]);
  endproperty
  a_mask_follows: assert property (p_mask_follows)
    else $error("Writable mask differs from size field");

  property p_default_max;
    @(posedge core_clk) disable iff (rst)
      $past(rst) |-> aperture_size_mb == 9'h100;
  endproperty
  a_default_max: assert property (p_default_max)
    else $error("Aperture not maximum after reset");

  property p_decode_4mb;
    @(posedge core_clk) disable iff (rst)
      aperture_size_mask == 6'h3f |-> aperture_size_mb == 9'h004;
  endproperty
  a_decode_4mb: assert property (p_decode_4mb)
    else $error("Size code 111111 not decoded as 4 MB");

  property p_base_write;
    @(posedge core_clk) disable iff (rst)
      cfg_req.wr && sel_base && cfg_req.be == 4'hf
      |=> table_base_pointer_field == $past(cfg_req.wdata[31:12]);
  endproperty
  a_base_write: assert property (p_base_write)
    else $error("Table base write lost");

  property p_fetch_addr;
    @(posedge core_clk) disable iff (rst)
      state == gas_pkg::GAS_IDLE && need_fetch |=> fetch.valid
        && fetch.addr == {$past(table_base_pointer_field), 12'h000}
        + 32'({$past(xlat_page), 2'b00});
  endproperty
  a_fetch_addr: assert property (p_fetch_addr)
    else $error("Fetch address not relative to table base");

  property p_bypass;
    @(posedge core_clk) disable iff (rst)
      state == gas_pkg::GAS_IDLE && xlat_req && !translation_buffer_enable |=> xlat_busy;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Disabled buffer did not force a fetch");

  c_size_write: cover property (@(posedge core_clk) disable iff (rst)
    cfg_req.wr && sel_size);
  c_base_read: cover property (@(posedge core_clk) disable iff (rst)
    cfg_rvalid && cfg_rdata != 32'h00000000);
  c_fetch_done: cover property (@(posedge core_clk) disable iff (rst)
    xlat_busy ##1 !xlat_busy);
endmodule // gas_aperture_regs

// file: verif/gas_aperture_regs_tb.sv
`timescale 1ns/1ns
module gas_aperture_regs_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  gas_pkg::gas_cfg_req_t cfg_req = '0;
  logic [31:0] cfg_rdata;
  logic cfg_rvalid;
  logic [5:0] aperture_base_writable;
  logic [8:0] aperture_size_mb;
  logic translation_buffer_enable = 1'b0;
  logic translation_buffer_flush;
  logic xlat_req = 1'b0;
  logic [15:0] xlat_page = 16'h0000;
  logic xlat_hit = 1'b0;
  logic xlat_busy;
  gas_pkg::gas_fetch_t fetch;
  logic fetch_ack = 1'b0;
  int err_count = 0;
  int n_checks = 0;
  // Size codes and the aperture each one selects, largest first
  logic [5:0] codes [7] = '{6'h00, 6'h20, 6'h30, 6'h38, 6'h3c, 6'h3e, 6'h3f};
  logic [8:0] sizes [7] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004};

  // 125 MHz core clock
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  gas_aperture_regs #(.PAGE_W(16)) uut (
    .core_clk(core_clk),
    .rst(rst),
    .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid),
    .aperture_base_writable(aperture_base_writable),
    .aperture_size_mb(aperture_size_mb),
    .translation_buffer_enable(translation_buffer_enable),
    .translation_buffer_flush(translation_buffer_flush),
    .xlat_req(xlat_req),
    .xlat_page(xlat_page),
    .xlat_hit(xlat_hit),
    .xlat_busy(xlat_busy),
    .fetch(fetch),
    .fetch_ack(fetch_ack)
  );

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write pulse for one edge; the extra ns lets the registered size and base fields update
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: 4'hf, wdata: d};
    @(posedge core_clk);
    cfg_req <= '0;
    #1;
  endtask

  // Read data is registered, so it is sampled just after the taking edge
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0};
    @(posedge core_clk);
    cfg_req <= '0;
    #1;
    chk({31'h0, cfg_rvalid}, 32'h1);
    chk(cfg_rdata, exp);
  endtask

  // One translation request; when a fetch is expected it is acknowledged
  task automatic xlat(input logic [15:0] pg, input logic hit, input logic [31:0] ea,
                      input logic ef);
    @(posedge core_clk);
    xlat_req <= 1'b1;
    xlat_page <= pg;
    xlat_hit <= hit;
    @(posedge core_clk);
    xlat_req <= 1'b0;
    #1;
    chk({31'h0, fetch.valid}, {31'h0, ef});
    chk({31'h0, xlat_busy}, {31'h0, ef});
    if (ef) begin
      chk(fetch.addr, ea);
      @(posedge core_clk);
      fetch_ack <= 1'b1;
      @(posedge core_clk);
      fetch_ack <= 1'b0;
      #1;
      chk({31'h0, fetch.valid}, 32'h0);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk({23'h0, aperture_size_mb}, 32'h100);
    chk({26'h0, aperture_base_writable}, 32'h0);
    cfg_rd(8'hb4, 32'h0);
    cfg_rd(8'hb8, 32'h0);
    // Firmware sets a practical size before enumeration; 64 MB frees base bits 27..26
    cfg_wr(8'hb4, 32'h00000030);
    chk({26'h0, aperture_base_writable}, 32'h30);
    chk({23'h0, aperture_size_mb}, 32'h40);
    // Reserved bits 7:6 are written high every time and must not stick
    for (int i = 0; i < 7; i++) begin
      cfg_wr(8'hb4, {24'hffffff, 2'b11, codes[i]});
      chk({23'h0, aperture_size_mb}, {23'h0, sizes[i]});
      chk({26'h0, aperture_base_writable}, {26'h0, codes[i]});
      cfg_rd(8'hb4, {26'h0, codes[i]});
    end
    cfg_wr(8'hb8, 32'hffffffff);
    cfg_rd(8'hb8, 32'hfffff000);
    cfg_rd(8'hbc, 32'h0);
    chk({31'h0, translation_buffer_flush}, 32'h1);
    // Disabled buffer: a hit is bypassed and the entry is fetched anyway
    cfg_wr(8'hb8, 32'h12345abc);
    xlat(16'h0003, 1'b1, 32'h1234500c, 1'b1);
    @(posedge core_clk);
    translation_buffer_enable <= 1'b1;
    #1;
    chk({31'h0, translation_buffer_flush}, 32'h0);
    xlat(16'h0005, 1'b1, 32'h0, 1'b0);
    // Base rewritten during operation, buffer disabled around it, top page of the aperture
    @(posedge core_clk);
    translation_buffer_enable <= 1'b0;
    cfg_wr(8'hb8, 32'h0abcd000);
    @(posedge core_clk);
    translation_buffer_enable <= 1'b1;
    xlat(16'hffff, 1'b0, 32'h0ac0cffc, 1'b1);
    // A second reset returns the aperture to its largest size
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk({23'h0, aperture_size_mb}, 32'h100);
    cfg_rd(8'hb8, 32'h0);
    tally_and_finish;
  end

  // Hang guard: the whole run needs far fewer cycles than this
  initial begin
    #200000;
    err_count++;
    tally_and_finish;
  end
endmodule // gas_aperture_regs_tb
